/* shared/glue_pkg.sv */
// Constants for the system glue block: I/O decode ranges, strap positions and wait-state counts.
// Assumes a 10-bit CPU I/O address and an 8-bit data bus on one clock.
package glue_pkg;
    // I/O decode windows, upper bits of a 10-bit address.
    localparam logic [9:0] IO_DMA_BASE = 10'h000;
    localparam logic [9:0] IO_PIC_BASE = 10'h020;
    localparam logic [9:0] IO_TMR_BASE = 10'h040;
    localparam logic [9:0] IO_PIO_BASE = 10'h060;
    localparam logic [9:0] IO_PAGE_BASE = 10'h080;
    localparam logic [9:0] IO_NMI_BASE = 10'h0a0;
    localparam logic [9:0] IO_SPEED_BASE = 10'h0c0;
    localparam logic [9:0] IO_STATUS_BASE = 10'h0e0;
    // Window sizes expressed as the number of low address bits ignored.
    localparam int WIN32_LSB = 5;
    localparam int WIN4_LSB = 2;
    // Strap bit positions on the buffered address bus.
    localparam int STRAP_BOOT_LOOP = 0;
    localparam int STRAP_FPU = 1;
    localparam int STRAP_MEM_A = 2;
    localparam int STRAP_MEM_B = 3;
    localparam int STRAP_VIDEO_A = 4;
    localparam int STRAP_VIDEO_B = 5;
    localparam int STRAP_DRIVE_A = 6;
    localparam int STRAP_DRIVE_B = 7;
    localparam int STRAP_SPEED = 15;
    // Port B select bit and control register kbd clear bit, status field positions.
    localparam int PORTB_SEL_BIT = 3;
    localparam int PIO_KBD_CLR_BIT = 7;
    localparam int STATUS_MEM_A_BIT = 4;
    localparam int STATUS_MEM_B_BIT = 5;
    // PARALLEL_IO_UNIT register offsets inside its window.
    localparam logic [1:0] PIO_OFS_A = 2'h0;
    localparam logic [1:0] PIO_OFS_B = 2'h1;
    localparam logic [1:0] PIO_OFS_C = 2'h2;
    localparam logic [1:0] PIO_OFS_CTRL = 2'h3;
    // Wait states per cycle type and speed.
    localparam logic [2:0] WS_IO_LOW = 3'h1;
    localparam logic [2:0] WS_IO_HIGH = 3'h4;
    localparam logic [2:0] WS_DMA_LOW = 3'h1;
    localparam logic [2:0] WS_DMA_HIGH = 3'h1;
    localparam logic [2:0] WS_MEMX_LOW = 3'h0;
    localparam logic [2:0] WS_MEMX_HIGH = 3'h2;
    localparam logic [2:0] WS_ONBOARD = 3'h0;
    // CPU clock is the reference divided by three, one third high.
    localparam logic [1:0] CPU_DIV_LAST = 2'h2;
    localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

/* logic/xt_system_glue_logic.sv */
// System glue logic: straps, speed control, wait states, I/O decode, keyboard register, parity, channel routing.
// Assumes the CPU cycle inputs are synchronous to i_ref_clk and held for the whole cycle.
`timescale 1ns/1ps
module xt_system_glue_logic (
    input wire logic i_ref_clk, // Reference clock, 100 MHz.
    input wire logic i_sys_rst, // Synchronous reset, active high.
    input wire logic [15:0] i_xa, // Buffered address bus, carries straps in reset.
    input wire logic [9:0] i_io_addr, // CPU I/O address.
    input wire logic [7:0] i_io_wdata, // CPU write data.
    input wire logic i_io_wr, // CPU I/O write strobe, one cycle.
    input wire logic i_io_rd, // CPU I/O read strobe, one cycle.
    input wire logic i_cyc_start, // Start of a bus cycle, one cycle.
    input wire logic i_cyc_io, // Cycle is a CPU I/O cycle.
    input wire logic i_cyc_dma, // Cycle is a DMA cycle.
    input wire logic i_mem_onboard, // Memory cycle decodes to on-board memory.
    input wire logic i_expansion_ready, // Expansion ready line, low extends.
    input wire logic i_kbd_valid, // Received keyboard byte strobe.
    input wire logic [7:0] i_kbd_byte, // Received keyboard byte.
    input wire logic [7:0] i_ram_data, // RAM data byte, read or write.
    input wire logic i_ram_par_in, // Parity bit read from RAM.
    input wire logic i_ram_rd, // RAM read sample strobe.
    input wire logic i_tmr_out0, // Timer channel 0 output.
    input wire logic i_tmr_out1, // Timer channel 1 output.
    input wire logic i_tmr_out2, // Timer channel 2 output.
    output logic [7:0] o_io_rdata, // Read data for the glue ports.
    output logic o_io_hit, // Read data is from a glue port.
    output logic [7:0] o_io_sel, // One-hot decode of the I/O map.
    output logic o_cpu_ready, // Ready to the CPU, low inserts waits.
    output logic o_cpu_clk, // CPU clock, one third duty.
    output logic o_speed_high, // Speed indicator, high in high speed.
    output logic o_irq0, // Interrupt level 0 from timer 0.
    output logic o_irq1, // Interrupt level 1, keyboard byte present.
    output logic o_refresh_req, // Refresh request to DMA channel 0.
    output logic o_speaker, // Speaker drive.
    output logic o_ram_par_out, // Parity bit for RAM writes.
    output logic o_parity_err, // Parity error, sticky until reset.
    output logic [7:0] o_nmi_mask // NMI mask register contents.
);
    typedef enum logic [1:0] {WS_IDLE, WS_COUNT, WS_EXT} ws_state_t;

    // Window compare, used for every entry of the map.
    function automatic logic in_window(input logic [9:0] a, input logic [9:0] base, input int lsb);
        in_window = ((a >> lsb) == (base >> lsb));
    endfunction

    logic [15:0] strap_q;
    logic [7:0] port_b_q, nmi_q, kbd_q, rdata_d, rdata_q, sel_q, port_c;
    logic kbd_full_q, speed_low_q, speed_high_q, speed_pend_q, hit_q, rdy_meta_q, rdy_sync_q;
    logic [1:0] div_q;
    logic [2:0] ws_cnt_q;
    ws_state_t ws_state_q;
    logic ready_q, cpu_clk_q, par_err_q, par_out_q, irq0_q, refr_q, spk_q;
    logic [7:0] sel_d;
    logic [2:0] ws_need;
    logic pio_hit, wr_speed, wr_pio_b, wr_pio_ctrl, wr_nmi, clk_boundary, speed_cur;

    // Address decode of the I/O map; the status window only answers reads.
    assign sel_d[0] = in_window(i_io_addr, glue_pkg::IO_DMA_BASE, glue_pkg::WIN32_LSB);
    assign sel_d[1] = in_window(i_io_addr, glue_pkg::IO_PIC_BASE, glue_pkg::WIN32_LSB);
    assign sel_d[2] = in_window(i_io_addr, glue_pkg::IO_TMR_BASE, glue_pkg::WIN32_LSB);
    assign sel_d[3] = in_window(i_io_addr, glue_pkg::IO_PIO_BASE, glue_pkg::WIN32_LSB);
    assign sel_d[4] = in_window(i_io_addr, glue_pkg::IO_PAGE_BASE, glue_pkg::WIN32_LSB);
    assign sel_d[5] = in_window(i_io_addr, glue_pkg::IO_NMI_BASE, glue_pkg::WIN32_LSB);
    assign sel_d[6] = in_window(i_io_addr, glue_pkg::IO_SPEED_BASE, glue_pkg::WIN4_LSB);
    assign sel_d[7] = in_window(i_io_addr, glue_pkg::IO_STATUS_BASE, glue_pkg::WIN4_LSB);
    assign pio_hit = sel_d[3];
    assign wr_speed = i_io_wr && sel_d[6];
    assign wr_pio_b = i_io_wr && pio_hit && (i_io_addr[1:0] == glue_pkg::PIO_OFS_B);
    assign wr_pio_ctrl = i_io_wr && pio_hit && (i_io_addr[1:0] == glue_pkg::PIO_OFS_CTRL);
    assign wr_nmi = i_io_wr && sel_d[5];

    // Port C shows one of two strap groups chosen by port B bit 3.
    assign port_c = port_b_q[glue_pkg::PORTB_SEL_BIT]
        ? {4'h0, strap_q[glue_pkg::STRAP_DRIVE_B], strap_q[glue_pkg::STRAP_DRIVE_A],
           strap_q[glue_pkg::STRAP_VIDEO_B], strap_q[glue_pkg::STRAP_VIDEO_A]}
        : {6'h00, strap_q[glue_pkg::STRAP_FPU], strap_q[glue_pkg::STRAP_BOOT_LOOP]};

    // Read mux; status is a plain view of the straps, nothing behind it is writable.
    always_comb begin
        rdata_d = glue_pkg::RESET_BYTE;
        if (sel_d[7]) begin
            rdata_d[glue_pkg::STATUS_MEM_A_BIT] = strap_q[glue_pkg::STRAP_MEM_A];
            rdata_d[glue_pkg::STATUS_MEM_B_BIT] = strap_q[glue_pkg::STRAP_MEM_B];
        end else if (sel_d[5]) begin
            rdata_d = nmi_q;
        end else if (pio_hit) begin
            case (i_io_addr[1:0])
                glue_pkg::PIO_OFS_A: rdata_d = kbd_q;
                glue_pkg::PIO_OFS_B: rdata_d = port_b_q;
                glue_pkg::PIO_OFS_C: rdata_d = port_c;
                default: rdata_d = glue_pkg::RESET_BYTE;
            endcase
        end
    end

    // Straps follow the address pins only while reset holds, then freeze.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            strap_q <= i_xa;
        end
    end

    // Bus read and decode outputs, registered.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rdata_q <= glue_pkg::RESET_BYTE;
            hit_q <= 1'b0;
            sel_q <= glue_pkg::RESET_BYTE;
        end else begin
            rdata_q <= i_io_rd ? rdata_d : glue_pkg::RESET_BYTE;
            hit_q <= i_io_rd && (sel_d[7] || sel_d[5] || pio_hit);
            sel_q <= (i_io_rd || i_io_wr) ? sel_d : glue_pkg::RESET_BYTE;
        end
    end

    // Port B and NMI mask registers.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            port_b_q <= glue_pkg::RESET_BYTE;
            nmi_q <= glue_pkg::RESET_BYTE;
        end else begin
            if (wr_pio_b) port_b_q <= i_io_wdata;
            if (wr_nmi) nmi_q <= i_io_wdata;
        end
    end

    // Keyboard byte holder; a new byte beats a simultaneous clear so nothing is lost.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            kbd_q <= glue_pkg::RESET_BYTE;
            kbd_full_q <= 1'b0;
        end else if (i_kbd_valid) begin
            kbd_q <= i_kbd_byte;
            kbd_full_q <= 1'b1;
        end else if (wr_pio_ctrl && i_io_wdata[glue_pkg::PIO_KBD_CLR_BIT]) begin
            kbd_q <= glue_pkg::RESET_BYTE;
            kbd_full_q <= 1'b0;
        end
    end

    // Speed state: strap during reset, software toggles later, applied at a CPU clock boundary.
    // A toggle is parked as pending so a mid-phase write never chops a clock phase.
    assign clk_boundary = (div_q == glue_pkg::CPU_DIV_LAST);
    assign speed_cur = speed_low_q;
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            speed_low_q <= strap_q[glue_pkg::STRAP_SPEED];
            speed_high_q <= ~strap_q[glue_pkg::STRAP_SPEED];
            speed_pend_q <= 1'b0;
        end else begin
            if (clk_boundary) begin
                speed_low_q <= speed_cur ^ (speed_pend_q ^ wr_speed);
                speed_high_q <= ~(speed_cur ^ (speed_pend_q ^ wr_speed));
                speed_pend_q <= 1'b0;
            end else if (wr_speed) begin
                speed_pend_q <= ~speed_pend_q;
            end
        end
    end

    // CPU clock divider: one reference period high out of three.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            div_q <= 2'h0;
            cpu_clk_q <= 1'b0;
        end else begin
            div_q <= clk_boundary ? 2'h0 : div_q + 2'h1;
            cpu_clk_q <= clk_boundary;
        end
    end

    // Two-flop synchroniser on the expansion ready line.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            rdy_meta_q <= 1'b1;
            rdy_sync_q <= 1'b1;
        end else begin
            rdy_meta_q <= i_expansion_ready;
            rdy_sync_q <= rdy_meta_q;
        end
    end

    // Wait count selection by cycle type and speed.
    assign ws_need = i_cyc_io ? (speed_low_q ? glue_pkg::WS_IO_LOW : glue_pkg::WS_IO_HIGH)
        : i_cyc_dma ? (speed_low_q ? glue_pkg::WS_DMA_LOW : glue_pkg::WS_DMA_HIGH)
        : i_mem_onboard ? glue_pkg::WS_ONBOARD
        : (speed_low_q ? glue_pkg::WS_MEMX_LOW : glue_pkg::WS_MEMX_HIGH);

    // Wait generator: fixed waits, then hold while synchronised ready stays low.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            ws_state_q <= WS_IDLE;
            ws_cnt_q <= 3'h0;
            ready_q <= 1'b1;
        end else begin
            case (ws_state_q)
                WS_IDLE: begin
                    if (i_cyc_start && (ws_need != 3'h0)) begin
                        ws_cnt_q <= ws_need;
                        ready_q <= 1'b0;
                        ws_state_q <= WS_COUNT;
                    end else if (i_cyc_start) begin
                        ready_q <= rdy_sync_q;
                        ws_state_q <= rdy_sync_q ? WS_IDLE : WS_EXT;
                    end
                end
                WS_COUNT: begin
                    if (ws_cnt_q == 3'h1) begin
                        ready_q <= rdy_sync_q;
                        ws_state_q <= rdy_sync_q ? WS_IDLE : WS_EXT;
                    end
                    ws_cnt_q <= ws_cnt_q - 3'h1;
                end
                WS_EXT: begin
                    if (rdy_sync_q) begin
                        ready_q <= 1'b1;
                        ws_state_q <= WS_IDLE;
                    end
                end
                default: ws_state_q <= WS_IDLE;
            endcase
        end
    end

    // Parity: even parity generated on writes, checked on reads; error is sticky.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            par_out_q <= 1'b0;
            par_err_q <= 1'b0;
        end else begin
            par_out_q <= ^i_ram_data;
            if (i_ram_rd && ((^i_ram_data) != i_ram_par_in)) par_err_q <= 1'b1;
        end
    end

    // Fixed channel routing; refresh requests go to DMA channel 0 only.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            irq0_q <= 1'b0;
            refr_q <= 1'b0;
            spk_q <= 1'b0;
        end else begin
            irq0_q <= i_tmr_out0;
            refr_q <= i_tmr_out1;
            spk_q <= i_tmr_out2 && port_b_q[1] && port_b_q[0];
        end
    end

    // Every output is a flop copy, so no decode glitch reaches the pins.
    assign o_io_rdata = rdata_q;
    assign o_io_hit = hit_q;
    assign o_io_sel = sel_q;
    assign o_cpu_ready = ready_q;
    assign o_cpu_clk = cpu_clk_q;
    assign o_speed_high = speed_high_q;
    assign o_irq0 = irq0_q;
    assign o_irq1 = kbd_full_q;
    assign o_refresh_req = refr_q;
    assign o_speaker = spk_q;
    assign o_ram_par_out = par_out_q;
    assign o_parity_err = par_err_q;
    assign o_nmi_mask = nmi_q;

    // Straps must not move after reset.
    property p_strap_frozen;
        @(posedge i_ref_clk) disable iff (i_sys_rst) 1'b1 ##1 !i_sys_rst |-> $stable(strap_q);
    endproperty
    a_strap_frozen: assert property (p_strap_frozen) else $error("strap changed after reset");

    property p_speed_strap;
        @(posedge i_ref_clk) $fell(i_sys_rst) |-> o_speed_high == !strap_q[15];
    endproperty
    a_speed_strap: assert property (p_speed_strap) else $error("speed strap not applied");

    property p_kbd_irq;
        @(posedge i_ref_clk) disable iff (i_sys_rst) i_kbd_valid |=> o_irq1 && kbd_q == $past(i_kbd_byte);
    endproperty
    a_kbd_irq: assert property (p_kbd_irq) else $error("keyboard irq not raised");

    property p_kbd_clear;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            wr_pio_ctrl && i_io_wdata[7] && !i_kbd_valid |=> !o_irq1;
    endproperty
    a_kbd_clear: assert property (p_kbd_clear) else $error("keyboard clear ignored");

    // Four fixed waits in high speed I/O, whatever the ready line does.
    sequence s_io_high;
        i_cyc_start && i_cyc_io && !speed_low_q;
    endsequence
    property p_io_high_waits;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            (s_io_high and (ws_state_q == WS_IDLE)) |=> !o_cpu_ready [*4];
    endproperty
    a_io_high_waits: assert property (p_io_high_waits) else $error("high speed io waits short");

    property p_onboard_nowait;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            ws_state_q == WS_IDLE && i_cyc_start && !i_cyc_io && !i_cyc_dma && i_mem_onboard && rdy_sync_q
            |=> o_cpu_ready;
    endproperty
    a_onboard_nowait: assert property (p_onboard_nowait) else $error("onboard memory delayed");

    // A DMA cycle gets one fixed wait at either speed, then follows the synchronised ready.
    sequence s_dma_start;
        i_cyc_start && i_cyc_dma && !i_cyc_io && ws_state_q == WS_IDLE;
    endsequence
    property p_dma_one_wait;
        @(posedge i_ref_clk) disable iff (i_sys_rst) s_dma_start |=> !o_cpu_ready ##1 o_cpu_ready == $past(rdy_sync_q);
    endproperty
    a_dma_one_wait: assert property (p_dma_one_wait) else $error("dma wait count wrong");

    property p_speed_boundary;
        @(posedge i_ref_clk) disable iff (i_sys_rst) !$stable(speed_low_q) |-> $past(div_q) == 2'h2;
    endproperty
    a_speed_boundary: assert property (p_speed_boundary) else $error("speed changed mid clock");

    property p_toggle;
        @(posedge i_ref_clk) disable iff (i_sys_rst)
            wr_speed && clk_boundary && !speed_pend_q |=> speed_low_q != $past(speed_low_q);
    endproperty
    a_toggle: assert property (p_toggle) else $error("speed write did not toggle");

endmodule // xt_system_glue_logic

/* sim/exp_slot_model.sv */
// Behavioural slow expansion card that stretches bus cycles through the ready line.
// Assumes the bench pulses i_stretch for one clock with the stretch length on i_len.
`timescale 1ns/1ps
module exp_slot_model (
    input wire logic i_ref_clk, // System clock.
    input wire logic i_sys_rst, // Synchronous reset, active high.
    input wire logic i_stretch, // Request to hold ready low.
    input wire logic [7:0] i_len, // Cycles to hold ready low.
    output logic o_expansion_ready // Ready line, driven high again by the card when the count runs out.
);
    logic [7:0] left_q;
    // The card holds ready low for a set time; the card drives it high again itself once the count runs out.
    always_ff @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            left_q <= 8'h00;
        end else if (i_stretch) begin
            left_q <= i_len;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end
    assign o_expansion_ready = (left_q == 8'h00);
endmodule // exp_slot_model

/* sim/xt_system_glue_logic_bench.sv */
// Self-checking bench for the system glue block: I/O port tasks, bus cycles, straps and routing.
// Assumes one 100 MHz clock and a slow expansion card model on the ready line.
`timescale 1ns/1ps
module xt_system_glue_logic_bench;
    logic clk = 1'b0;
    logic rst, wr, rd, cstart, cio, cdma, onb, kv, prin, ramrd, t0, t1, t2, sgo, xrdy;
    logic [15:0] xa;
    logic [9:0] addr;
    logic [7:0] wd, kb, ramd, slen, rdata, sel, nmi, r_data, r_sel;
    logic hit, r_hit, crdy, cclk, spd, irq0, irq1, refr, spk, parout, perr;
    logic [9:0] bases [8];
    logic [9:0] tops [8] = '{10'h01f, 10'h01f, 10'h01f, 10'h01f, 10'h01f, 10'h000, 10'h003, 10'h003};
    int fails = 0;
    int n_tests = 0;
    int cnt;

    xt_system_glue_logic DUT (.i_ref_clk(clk), .i_sys_rst(rst), .i_xa(xa), .i_io_addr(addr),
        .i_io_wdata(wd), .i_io_wr(wr), .i_io_rd(rd), .i_cyc_start(cstart), .i_cyc_io(cio),
        .i_cyc_dma(cdma), .i_mem_onboard(onb), .i_expansion_ready(xrdy), .i_kbd_valid(kv),
        .i_kbd_byte(kb), .i_ram_data(ramd), .i_ram_par_in(prin), .i_ram_rd(ramrd), .i_tmr_out0(t0),
        .i_tmr_out1(t1), .i_tmr_out2(t2), .o_io_rdata(rdata), .o_io_hit(hit), .o_io_sel(sel),
        .o_cpu_ready(crdy), .o_cpu_clk(cclk), .o_speed_high(spd), .o_irq0(irq0), .o_irq1(irq1),
        .o_refresh_req(refr), .o_speaker(spk), .o_ram_par_out(parout), .o_parity_err(perr),
        .o_nmi_mask(nmi));
    exp_slot_model slot (.i_ref_clk(clk), .i_sys_rst(rst), .i_stretch(sgo), .i_len(slen),
        .o_expansion_ready(xrdy));

    // Free-running clock, 10 ns period.
    always #5 clk = ~clk;

    // Inputs always change 1 ns after the rising edge, away from sampling.
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // One-cycle write strobe, then an idle edge so strobes never merge.
    task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
        addr = a;
        wd = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask

    // Read answer is registered: it stands only in the cycle after the strobe.
    task automatic io_rd(input logic [9:0] a);
        addr = a;
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        r_data = rdata;
        r_hit = hit;
        r_sel = sel;
        tick(1);
    endtask

    // Start a bus cycle and count the cycles with ready low, bounded against a hang.
    task automatic bus_cyc(input logic io, input logic dma, input logic ob, input logic [7:0] st);
        cio = io;
        cdma = dma;
        onb = ob;
        cstart = 1'b1;
        sgo = (st != 8'h00);
        slen = st;
        tick(1);
        cstart = 1'b0;
        sgo = 1'b0;
        cnt = 0;
        while (crdy !== 1'b1 && cnt < 40) begin
            cnt++;
            tick(1);
        end
        if (cnt == 40) begin
            fails++;
            complete_run();
        end
        tick(2);
    endtask

    // Toggle speed and wait, bounded, for the indicator to follow at a clock boundary.
    task automatic toggle_speed(input logic [1:0] ofs, input logic [7:0] d, input logic want);
        io_wr(glue_pkg::IO_SPEED_BASE | {8'h00, ofs}, d);
        cnt = 0;
        while (spd !== want && cnt < 6) begin
            cnt++;
            tick(1);
        end
        check("speed_toggle", {15'h0000, spd}, {15'h0000, want});
    endtask

    initial begin
        bases = '{glue_pkg::IO_DMA_BASE, glue_pkg::IO_PIC_BASE, glue_pkg::IO_TMR_BASE,
            glue_pkg::IO_PIO_BASE, glue_pkg::IO_PAGE_BASE, glue_pkg::IO_NMI_BASE,
            glue_pkg::IO_SPEED_BASE, glue_pkg::IO_STATUS_BASE};
        {wr, rd, cstart, cio, cdma, onb, kv, prin, ramrd, t0, t1, t2, sgo} = '0;
        {addr, wd, kb, ramd, slen} = '0;
        rst = 1'b1;
        xa = 16'h80a5; // Low speed, boot 1, mem 01, video 10, drives 10.
        tick(6);
        rst = 1'b0;
        xa = 16'h7f5a; // Inverted straps after reset must be ignored.
        tick(1);
        check("speed_after_reset", {15'h0000, spd}, 16'h0000);
        io_rd(glue_pkg::IO_STATUS_BASE);
        check("status", {7'h00, r_hit, r_data}, 16'h0110);
        io_wr(glue_pkg::IO_STATUS_BASE | 10'h003, 8'hff);
        io_rd(glue_pkg::IO_STATUS_BASE | 10'h003);
        check("status_ro", {8'h00, r_data}, 16'h0010);
        io_wr(glue_pkg::IO_PIO_BASE | 10'h001, 8'h00);
        io_rd(glue_pkg::IO_PIO_BASE | 10'h002);
        check("portc_sel0", {14'h0000, r_data[1:0]}, 16'h0001);
        io_wr(glue_pkg::IO_PIO_BASE | 10'h001, 8'h08);
        io_rd(glue_pkg::IO_PIO_BASE | 10'h002);
        check("portc_sel1", {12'h000, r_data[3:0]}, 16'h000a);
        $display("test straps done");
        for (int i = 0; i < 8; i++) begin
            io_rd(bases[i]);
            check("decode_base", {8'h00, r_sel}, 16'h0001 << i);
            io_rd(bases[i] | tops[i]);
            check("decode_top", {8'h00, r_sel}, 16'h0001 << i);
        end
        io_rd(10'h200);
        check("unmapped", {7'h00, r_hit, r_sel}, 16'h0000);
        io_wr(glue_pkg::IO_NMI_BASE, 8'h80);
        io_rd(glue_pkg::IO_NMI_BASE);
        check("nmi_mask", {nmi, r_data}, 16'h8080);
        $display("test decode done");
        // Low speed table, then high speed table: io, dma, expansion memory, on-board memory.
        for (int s = 0; s < 2; s++) begin
            bus_cyc(1'b1, 1'b0, 1'b0, 8'h00);
            check("ws_io", 16'(cnt), s ? 16'h0004 : 16'h0001);
            bus_cyc(1'b0, 1'b1, 1'b0, 8'h00);
            check("ws_dma", 16'(cnt), 16'h0001);
            bus_cyc(1'b0, 1'b0, 1'b0, 8'h00);
            check("ws_memx", 16'(cnt), s ? 16'h0002 : 16'h0000);
            bus_cyc(1'b0, 1'b0, 1'b1, 8'h00);
            check("ws_onboard", 16'(cnt), 16'h0000);
            if (s == 0) begin
                toggle_speed(2'h3, 8'h00, 1'b1);
            end
        end
        bus_cyc(1'b1, 1'b0, 1'b0, 8'h08);
        check("ws_stretch", {15'h0000, cnt >= 8 && cnt <= 11}, 16'h0001);
        toggle_speed(2'h1, 8'hff, 1'b0);
        // The CPU clock is high for one reference period out of three.
        cnt = 0;
        repeat (6) begin
            tick(1);
            cnt += int'(cclk);
        end
        check("cpu_clk_duty", 16'(cnt), 16'h0002);
        $display("test speed and waits done");
        kb = 8'h5a;
        kv = 1'b1;
        tick(1);
        kv = 1'b0;
        tick(1);
        io_rd(glue_pkg::IO_PIO_BASE);
        check("kbd_data", {6'h00, irq1, r_hit, r_data}, 16'h035a);
        io_wr(glue_pkg::IO_PIO_BASE | 10'h003, 8'h80);
        io_rd(glue_pkg::IO_PIO_BASE);
        check("kbd_clear", {7'h00, irq1, r_data}, 16'h0000);
        io_wr(glue_pkg::IO_PIO_BASE | 10'h001, 8'h03);
        {t2, t1, t0} = 3'b101;
        tick(2);
        check("route_a", {13'h0000, spk, refr, irq0}, 16'h0005);
        {t2, t1, t0} = 3'b010;
        tick(2);
        check("route_b", {13'h0000, spk, refr, irq0}, 16'h0002);
        ramd = 8'h07;
        prin = 1'b1;
        ramrd = 1'b1;
        tick(2);
        check("parity_ok", {14'h0000, parout, perr}, 16'h0002);
        ramd = 8'h03;
        tick(2);
        ramrd = 1'b0;
        tick(3);
        check("parity_err", {14'h0000, parout, perr}, 16'h0001);
        $display("test keyboard routing parity done");
        // Second reset in mid-run with the high speed strap.
        rst = 1'b1;
        xa = 16'h0000;
        tick(3);
        rst = 1'b0;
        xa = 16'hffff;
        tick(1);
        io_rd(glue_pkg::IO_STATUS_BASE);
        check("rereset", {7'h00, spd, r_data}, 16'h0100);
        $display("test second reset done");
        complete_run();
    end
endmodule // xt_system_glue_logic_bench
